// *** cfgh_consts.svh ***
// constants for the configuration header register block
`ifndef CFGH_CONSTS_SVH
`define CFGH_CONSTS_SVH
`define CFGH_NUM_BARS        6
`define CFGH_BAR_ADDR_LSB    4
`define CFGH_BAR_PF_BIT      3
`define CFGH_CFG_IDX_BAR0    6'h04
`define CFGH_CFG_IDX_BARLAST 6'h09
`define CFGH_CFG_IDX_SUBSYS  6'h0b
`define CFGH_CFG_IDX_CAP     6'h0d
`define CFGH_CFG_IDX_INTR    6'h0f
`define CFGH_CAP_PTR_RST     8'h40
`define CFGH_INT_PIN_VAL     8'h01
`define CFGH_RST_ZERO8       8'h00
`define CFGH_RST_ZERO16      16'h0000
`define CFGH_MMR_CLKSTAT     12'h040
`define CFGH_MMR_SUBSYS      12'h12c
`define CFGH_MMR_CAP         12'h134
`define CFGH_MMR_INTR        12'h13c
`define CFGH_MMR_BARMIR0     12'h1e0
`define CFGH_MMR_BARMIR_END  12'h1f8
`define CFGH_PERI_LO0        12'h010
`define CFGH_PERI_HI0        12'h034
`define CFGH_PERI_LO1        12'h314
`define CFGH_PERI_HI1        12'h390
`define CFGH_HOST_WIN_BAR    0
`define CFGH_LANE_LINE       0
`define CFGH_LANE_PIN        1
`define CFGH_LANE_BURST      2
`define CFGH_LANE_ACCESS     3
`define CFGH_HINT_UNIT_NS    250
`endif

// *** cfgh_pkg.sv ***
// types shared by the configuration header register block
`include "cfgh_consts.svh"
package cfgh_pkg;
  typedef enum logic [1:0] {cfgh_src_cfg, cfgh_src_host, cfgh_src_mmr} cfgh_src_t;
  typedef enum logic {cfgh_rd_misc, cfgh_rd_bar} cfgh_rsel_t;
  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic [15:0] board_ident;
    logic [15:0] board_maker_ident;
    logic [7:0]  irq_routing_line;
    logic [7:0]  burst_length_hint;
    logic [7:0]  access_interval_hint;
    logic        p1_valid;
    cfgh_src_t   p1_src;
    cfgh_rsel_t  p1_rsel;
    logic        p1_err;
    logic [31:0] p1_misc;
    logic        ack_cfg;
    logic        ack_host;
    logic        ack_mmr;
    logic        err;
    logic [31:0] rdata;
  } cfgh_state_t;
endpackage : cfgh_pkg

// *** cfgh_bar_if.sv ***
// carrier between the register control and the window address store
`timescale 1ns/1ps
`default_nettype none
interface cfgh_bar_if #(parameter int N = 6, parameter int W = 28) ();
  logic                 we;
  logic [$clog2(N)-1:0] widx;
  logic [W-1:0]         wdata;
  logic [W-1:0]         wmask;
  logic [$clog2(N)-1:0] ridx;
  logic [W-1:0]         rdata;
  logic [N-1:0][W-1:0]  entries;
  modport ctrl (output we, widx, wdata, wmask, ridx, input rdata, entries);
  modport mem  (input we, widx, wdata, wmask, ridx, output rdata, entries);
endinterface : cfgh_bar_if
`default_nettype wire

// *** cfgh_bar_mem.sv ***
// store for the writable address bits of the base address windows
`timescale 1ns/1ps
`default_nettype none
module cfgh_bar_mem #(
  parameter int N = 6,  // number of windows
  parameter int W = 28  // stored address bits per window
) (
  input wire logic mclk,   // clock
  input wire logic rst,    // synchronous reset, high
  cfgh_bar_if.mem  bi      // access from the control
);
  typedef struct packed {
    logic [N-1:0][W-1:0] ent;
    logic [W-1:0]        rdata;
  } cfgh_mem_state_t;

  cfgh_mem_state_t st_reg;
  cfgh_mem_state_t st_next;

  // masked write keeps the bits the mask protects; read gives old data
  always_comb begin
    st_next = st_reg;
    st_next.rdata = st_reg.ent[bi.ridx];
    if (bi.we) begin
      st_next.ent[bi.widx] = (st_reg.ent[bi.widx] & ~bi.wmask) | (bi.wdata & bi.wmask); // RQ1
    end
  end

  // address bits reset to zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bi.rdata   = st_reg.rdata;
  assign bi.entries = st_reg.ent;
endmodule : cfgh_bar_mem
`default_nettype wire

// *** cfgh_regs.sv ***
// configuration header upper fields with config port, local mirror port and host window
// Notes on behaviour
// RQ1 - Host writes to window address bits 31-4 change only the bits that the window's write mask allows.
// RQ2 - Window bit 3 is read-only and reflects the prefetchable enable bit of the window's mask.
// RQ3 - Window bits 2-1 always read zero for 32-bit decoding, and writes to them do nothing.
// RQ4 - Window bit 0 always reads zero because only memory space is decoded.
// RQ5 - The board ident is read-only from the config port and reads zero after reset.
// RQ6 - The board maker ident is read-only from the config port and reads zero after reset.
// RQ7 - The capability list pointer is read-only and reads 40h, the first capability entry.
// RQ8 - The irq routing line is read-write, resets to zero and is written by the host.
// RQ9 - The irq pin field is read-only and fixed at 01h for interrupt line A.
// RQ10 - The burst length hint is read-write, resets to zero and counts 0.25 us steps.
// RQ11 - The access interval hint is read-write, resets to zero and counts 0.25 us steps.
// RQ12 - The local processor can read every header register through memory-mapped mirrors.
// RQ13 - A host access that hits the register window reaches the memory-mapped registers.
// RQ14 - Bus clock domain registers answer only while the bus clock is running.
// RQ15 - Peripheral clock domain registers answer even when the bus clock is stopped.
// RQ16 - Config writes to read-only fields complete normally and change nothing.
`timescale 1ns/1ps
`default_nettype none
`include "cfgh_consts.svh"
module cfgh_regs #(
  parameter int NUM_BARS = `CFGH_NUM_BARS  // number of base address windows
) (
  input  wire logic                      mclk,                  // 50 MHz clock
  input  wire logic                      rst,                   // synchronous reset, high
  input  wire logic                      cfg_req,               // config access request, held to ack
  input  wire logic                      cfg_we,                // config write
  input  wire logic [5:0]                cfg_idx,               // config dword index
  input  wire logic [3:0]                cfg_be,                // config byte enables
  input  wire logic [31:0]               cfg_wdata,             // config write data
  output logic [31:0]                    cfg_rdata,             // config read data
  output logic                           cfg_ack,               // config done pulse
  input  wire logic                      mmr_req,               // local access request, held to ack
  input  wire logic                      mmr_we,                // local write
  input  wire logic [11:0]               mmr_addr,              // local byte offset
  input  wire logic [31:0]               mmr_wdata,             // local write data
  output logic [31:0]                    mmr_rdata,             // local read data
  output logic                           mmr_ack,               // local done pulse
  output logic                           mmr_err,               // local access refused
  input  wire logic                      host_req,              // host memory access, held to ack
  input  wire logic                      host_we,               // host write
  input  wire logic [31:0]               host_addr,             // host bus address
  input  wire logic [31:0]               host_wdata,            // host write data
  output logic [31:0]                    host_rdata,            // host read data
  output logic                           host_ack,              // host done pulse
  output logic                           host_err,              // host miss or refusal
  input  wire logic [NUM_BARS-1:0][31:0] window_write_mask_reg, // per-window mask words
  input  wire logic                      bus_clk_running        // bus clock alive, async
);
  localparam int IW = $clog2(NUM_BARS);
  localparam int AW = 32 - `CFGH_BAR_ADDR_LSB;

  cfgh_pkg::cfgh_state_t st_reg;
  cfgh_pkg::cfgh_state_t st_next;

  cfgh_bar_if #(.N(NUM_BARS), .W(AW)) bi ();

  cfgh_bar_mem #(.N(NUM_BARS), .W(AW)) u_mem (
    .mclk (mclk),
    .rst  (rst),
    .bi   (bi.mem)
  );

  // expand byte enables to a bit mask
  function automatic logic [31:0] cfgh_lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : cfgh_lane_mask

  logic           grant;
  logic           m_go;
  logic           m_we;
  logic [11:0]    m_ofs;
  logic [31:0]    m_wd;
  logic           m_peri;
  logic           m_barmir;
  logic [11:0]    m_rel;
  logic [5:0]     c_rel;
  logic [31:0]    lmask;
  logic           host_hit;
  logic [AW-1:0]  win_mask;
  logic [IW-1:0]  pf_idx;

  // host window match on the bits the window mask decodes
  assign win_mask = window_write_mask_reg[`CFGH_HOST_WIN_BAR][31:`CFGH_BAR_ADDR_LSB];
  assign host_hit = (win_mask != '0) &&
                    (((host_addr[31:`CFGH_BAR_ADDR_LSB] ^ bi.entries[`CFGH_HOST_WIN_BAR]) & win_mask) == '0);

  // offsets that live in the peripheral clock domain
  assign m_peri = ((m_ofs >= `CFGH_PERI_LO0) && (m_ofs <= `CFGH_PERI_HI0)) ||
                  ((m_ofs >= `CFGH_PERI_LO1) && (m_ofs <= `CFGH_PERI_HI1)) ||
                  (m_ofs == `CFGH_MMR_CLKSTAT);
  assign m_barmir = (m_ofs >= `CFGH_MMR_BARMIR0) && (m_ofs < `CFGH_MMR_BARMIR_END);
  assign m_rel    = m_ofs - `CFGH_MMR_BARMIR0;
  assign c_rel    = cfg_idx - `CFGH_CFG_IDX_BAR0;
  assign lmask    = cfgh_lane_mask(cfg_be);

  // next-state: answer stage, arbitration, config decode, local decode
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = bus_clk_running;
    st_next.sync2 = st_reg.sync1;
    st_next.ack_cfg = 1'b0;
    st_next.ack_host = 1'b0;
    st_next.ack_mmr = 1'b0;
    st_next.p1_valid = 1'b0;
    bi.we = 1'b0;
    bi.widx = '0;
    bi.wdata = '0;
    bi.wmask = '0;
    bi.ridx = '0;
    pf_idx = '0;
    m_go = 1'b0;
    m_we = mmr_we;
    m_ofs = mmr_addr;
    m_wd = mmr_wdata;
    // one access in flight; a new one waits until the ack pulse has gone
    grant = !st_reg.p1_valid && !st_reg.ack_cfg && !st_reg.ack_host && !st_reg.ack_mmr;

    // answer stage: window data comes from the store one cycle later
    if (st_reg.p1_valid) begin
      unique case (st_reg.p1_src)
        cfgh_pkg::cfgh_src_cfg:  st_next.ack_cfg = 1'b1;
        cfgh_pkg::cfgh_src_host: st_next.ack_host = 1'b1;
        cfgh_pkg::cfgh_src_mmr:  st_next.ack_mmr = 1'b1;
      endcase
      st_next.err = st_reg.p1_err;
      if (st_reg.p1_rsel == cfgh_pkg::cfgh_rd_bar) begin
        st_next.rdata = {bi.rdata, 4'h0} | st_reg.p1_misc; // RQ3 RQ4
      end else begin
        st_next.rdata = st_reg.p1_misc;
      end
    end

    if (grant && (cfg_req || host_req || mmr_req)) begin
      st_next.p1_valid = 1'b1;
      st_next.p1_rsel = cfgh_pkg::cfgh_rd_misc;
      st_next.p1_err = 1'b0;
      st_next.p1_misc = '0;
      if (cfg_req) begin
        st_next.p1_src = cfgh_pkg::cfgh_src_cfg;
        if ((cfg_idx >= `CFGH_CFG_IDX_BAR0) && (cfg_idx <= `CFGH_CFG_IDX_BARLAST)) begin
          bi.ridx = c_rel[IW-1:0];
          pf_idx = c_rel[IW-1:0];
          st_next.p1_rsel = cfgh_pkg::cfgh_rd_bar;
          st_next.p1_misc[`CFGH_BAR_PF_BIT] = window_write_mask_reg[pf_idx][`CFGH_BAR_PF_BIT]; // RQ2
          // low four bits never reach the store
          bi.we = cfg_we;
          bi.widx = c_rel[IW-1:0];
          bi.wdata = cfg_wdata[31:`CFGH_BAR_ADDR_LSB];
          bi.wmask = window_write_mask_reg[c_rel[IW-1:0]][31:`CFGH_BAR_ADDR_LSB] &
                     lmask[31:`CFGH_BAR_ADDR_LSB]; // RQ1
        end else if (cfg_idx == `CFGH_CFG_IDX_SUBSYS) begin
          // writes acked but ignored
          st_next.p1_misc = {st_reg.board_ident, st_reg.board_maker_ident}; // RQ5 RQ6 RQ16
        end else if (cfg_idx == `CFGH_CFG_IDX_CAP) begin
          st_next.p1_misc[7:0] = `CFGH_CAP_PTR_RST; // RQ7 RQ16
        end else if (cfg_idx == `CFGH_CFG_IDX_INTR) begin
          st_next.p1_misc = {st_reg.access_interval_hint, st_reg.burst_length_hint,
                             `CFGH_INT_PIN_VAL, st_reg.irq_routing_line}; // RQ9
          if (cfg_we && cfg_be[`CFGH_LANE_LINE]) begin
            st_next.irq_routing_line = cfg_wdata[8*`CFGH_LANE_LINE +: 8]; // RQ8
          end
          if (cfg_we && cfg_be[`CFGH_LANE_BURST]) begin
            st_next.burst_length_hint = cfg_wdata[8*`CFGH_LANE_BURST +: 8]; // RQ10
          end
          if (cfg_we && cfg_be[`CFGH_LANE_ACCESS]) begin
            st_next.access_interval_hint = cfg_wdata[8*`CFGH_LANE_ACCESS +: 8]; // RQ11
          end
        end
      end else if (host_req) begin
        st_next.p1_src = cfgh_pkg::cfgh_src_host;
        m_we = host_we;
        m_ofs = host_addr[11:0];
        m_wd = host_wdata;
        if (host_hit) begin
          m_go = 1'b1; // RQ13
        end else begin
          st_next.p1_err = 1'b1;
        end
      end else begin
        st_next.p1_src = cfgh_pkg::cfgh_src_mmr;
        m_go = 1'b1;
      end

      // memory-mapped decode shared by the local port and the host window
      if (m_go) begin
        if (!m_peri && !st_reg.sync2) begin
          st_next.p1_err = 1'b1; // RQ14
        end else if (m_ofs == `CFGH_MMR_CLKSTAT) begin
          st_next.p1_misc[0] = st_reg.sync2; // RQ15
        end else if (m_ofs == `CFGH_MMR_SUBSYS) begin
          st_next.p1_misc = {st_reg.board_ident, st_reg.board_maker_ident}; // RQ12
          // board software loads the idents from the local side
          if (m_we) begin
            st_next.board_ident = m_wd[31:16];
            st_next.board_maker_ident = m_wd[15:0];
          end
        end else if (m_ofs == `CFGH_MMR_CAP) begin
          st_next.p1_misc[7:0] = `CFGH_CAP_PTR_RST; // RQ12
        end else if (m_ofs == `CFGH_MMR_INTR) begin
          st_next.p1_misc = {st_reg.access_interval_hint, st_reg.burst_length_hint,
                             `CFGH_INT_PIN_VAL, st_reg.irq_routing_line}; // RQ12
          if (m_we) begin
            st_next.irq_routing_line = m_wd[8*`CFGH_LANE_LINE +: 8];
            st_next.burst_length_hint = m_wd[8*`CFGH_LANE_BURST +: 8];
            st_next.access_interval_hint = m_wd[8*`CFGH_LANE_ACCESS +: 8];
          end
        end else if (m_barmir) begin
          // window mirrors are read-only here so the host alone places windows
          bi.ridx = m_rel[2 +: IW];
          pf_idx = m_rel[2 +: IW];
          st_next.p1_rsel = cfgh_pkg::cfgh_rd_bar;
          st_next.p1_misc[`CFGH_BAR_PF_BIT] = window_write_mask_reg[pf_idx][`CFGH_BAR_PF_BIT]; // RQ12
        end
      end
    end
  end

  // control state with defined reset values
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.board_ident <= `CFGH_RST_ZERO16;       // RQ5
      st_reg.board_maker_ident <= `CFGH_RST_ZERO16; // RQ6
      st_reg.irq_routing_line <= `CFGH_RST_ZERO8;   // RQ8
      st_reg.burst_length_hint <= `CFGH_RST_ZERO8;  // RQ10
      st_reg.access_interval_hint <= `CFGH_RST_ZERO8; // RQ11
    end else begin
      st_reg <= st_next;
    end
  end

  // one read data register serves all three ports
  assign cfg_rdata  = st_reg.rdata;
  assign mmr_rdata  = st_reg.rdata;
  assign host_rdata = st_reg.rdata;
  assign cfg_ack    = st_reg.ack_cfg;
  assign mmr_ack    = st_reg.ack_mmr;
  assign host_ack   = st_reg.ack_host;
  assign mmr_err    = st_reg.ack_mmr & st_reg.err;
  assign host_err   = st_reg.ack_host & st_reg.err;
endmodule : cfgh_regs
`default_nettype wire

// *** cfgh_regs_chk.sv ***
// assertions on the config header register ports
`timescale 1ns/1ps
`default_nettype none
module cfgh_regs_chk #(parameter int NUM_BARS = 6) (
  input wire logic                      mclk,                  // clock
  input wire logic                      rst,                   // reset
  input wire logic                      cfg_req,               // cfg request
  input wire logic                      cfg_we,                // cfg write
  input wire logic [5:0]                cfg_idx,               // cfg index
  input wire logic [31:0]               cfg_rdata,             // cfg data
  input wire logic                      cfg_ack,               // cfg answer
  input wire logic                      mmr_req,               // local request
  input wire logic [11:0]               mmr_addr,              // local offset
  input wire logic                      mmr_ack,               // local answer
  input wire logic                      mmr_err,               // local refusal
  input wire logic                      host_req,              // host request
  input wire logic                      host_ack,              // host answer
  input wire logic                      host_err,              // host miss
  input wire logic [NUM_BARS-1:0][31:0] window_write_mask_reg, // masks
  input wire logic                      bus_clk_running        // bus clock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // read answers, seen while the request is still held
  logic       rd_ans;
  logic       win_ans;
  logic [5:0] wsel;
  assign rd_ans  = cfg_ack && cfg_req && !cfg_we;
  assign win_ans = rd_ans && cfg_idx >= 6'h04 && cfg_idx <= 6'h09;
  assign wsel    = cfg_idx - 6'h04;
  property p_cfg_lat;
    $rose(cfg_req) && !mmr_req && !host_req && !cfg_ack && !mmr_ack && !host_ack
      |-> ##1 !cfg_ack ##1 cfg_ack ##1 !cfg_ack;
  endproperty
  a_cfg_lat: assert property (p_cfg_lat) else $error("config answer not on time");
  property p_cap;
    rd_ans && cfg_idx == 6'h0d |-> cfg_rdata[7:0] == 8'h40;
  endproperty
  a_cap: assert property (p_cap) else $error("capability pointer wrong");
  property p_pin;
    rd_ans && cfg_idx == 6'h0f |-> cfg_rdata[15:8] == 8'h01;
  endproperty
  a_pin: assert property (p_pin) else $error("irq pin not fixed");
  property p_win_type;
    win_ans |-> cfg_rdata[2:1] == 2'b00;
  endproperty
  a_win_type: assert property (p_win_type) else $error("window type bits set");
  property p_win_space;
    win_ans |-> !cfg_rdata[0];
  endproperty
  a_win_space: assert property (p_win_space) else $error("window space bit set");
  property p_win_pf;
    win_ans |-> cfg_rdata[3] == window_write_mask_reg[wsel][3];
  endproperty
  a_win_pf: assert property (p_win_pf) else $error("prefetch bit wrong");
  // sync needs two edges, so three stopped samples leave no doubt
  property p_bus_refuse;
    mmr_ack && mmr_addr == 12'h13c && !$past(bus_clk_running, 2) && !$past(bus_clk_running, 3)
      && !$past(bus_clk_running, 4) |-> mmr_err;
  endproperty
  a_bus_refuse: assert property (p_bus_refuse) else $error("bus domain access not refused");
  property p_peri_open;
    mmr_ack && mmr_addr == 12'h040 |-> !mmr_err;
  endproperty
  a_peri_open: assert property (p_peri_open) else $error("peripheral access refused");
  property p_host_miss;
    host_ack && window_write_mask_reg[0][31:4] == 28'h0 |-> host_err;
  endproperty
  a_host_miss: assert property (p_host_miss) else $error("closed window answered");
  c_cfg_wr: cover property (cfg_ack && cfg_req && cfg_we);
  c_mmr_err: cover property (mmr_ack && mmr_err);
  c_host_hit: cover property (host_ack && !host_err);
endmodule : cfgh_regs_chk
`default_nettype wire

// *** cfgh_host_model.sv ***
// external host issuing configuration cycles
`timescale 1ns/1ps
`default_nettype none
module cfgh_host_model (
  input  wire logic        mclk,      // clock
  input  wire logic        cfg_ack,   // answer pulse
  output logic             cfg_req,   // request
  output logic             cfg_we,    // write
  output logic [5:0]       cfg_idx,   // dword index
  output logic [3:0]       cfg_be,    // byte enables
  output logic [31:0]      cfg_wdata  // write data
);
  // idle bus at time zero
  initial begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_idx = 6'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  // one cycle held to the answer; gap gives slow hosts
  task automatic access(input logic we, input logic [5:0] idx, input logic [3:0] be,
                        input logic [31:0] d, input int gap);
    int n;
    repeat (gap) @(posedge mclk);
    #1;
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_idx = idx;
    cfg_be = be;
    cfg_wdata = d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (cfg_ack !== 1'b1 && n < 20);
    #1;
    cfg_req = 1'b0;
    cfg_wdata = ~d; // released data does not keep its value
  endtask : access
endmodule : cfgh_host_model
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the config header registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic e; logic dc; logic [31:0] d;} cfgh_exp_t;
  logic             mclk, rst, cfg_req, cfg_we, cfg_ack, mmr_req, mmr_we, mmr_ack, mmr_err;
  logic             host_req, host_we, host_ack, host_err, bus_clk_running, er;
  logic [5:0]       cfg_idx;
  logic [3:0]       cfg_be, b;
  logic [11:0]      mmr_addr;
  logic [31:0]      cfg_wdata, cfg_rdata, mmr_wdata, mmr_rdata, host_addr, host_wdata, host_rdata;
  logic [31:0]      seed, got, d, d2, m, ha;
  logic [5:0][31:0] mask;
  logic [31:0]      win [6];
  cfgh_exp_t        x;
  cfgh_exp_t        exp_q [$];
  int               n_fail, n_checks, cyc;
  cfgh_regs #(.NUM_BARS(6)) dut_u (.mclk, .rst, .cfg_req, .cfg_we, .cfg_idx, .cfg_be, .cfg_wdata,
    .cfg_rdata, .cfg_ack, .mmr_req, .mmr_we, .mmr_addr, .mmr_wdata, .mmr_rdata, .mmr_ack, .mmr_err,
    .host_req, .host_we, .host_addr, .host_wdata, .host_rdata, .host_ack, .host_err,
    .window_write_mask_reg(mask), .bus_clk_running);
  cfgh_host_model host_u (.mclk, .cfg_ack, .cfg_req, .cfg_we, .cfg_idx, .cfg_be, .cfg_wdata);
  function logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt
  task check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check
  task complete_run();
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // config cycle through the host model; writes note only the error flag
  task automatic cfg(input logic we, input logic [5:0] i, input logic [3:0] be, input logic [31:0] dd,
                     input logic [31:0] w);
    exp_q.push_back('{1'b0, we, w});
    host_u.access(we, i, be, dd, int'(nxt() % 32'h3));
  endtask : cfg
  // local (h=0) or host window (h=1) access, held to the answer
  task automatic loc(input logic h, input logic we, input logic [31:0] a, input logic [31:0] dd,
                     input logic e, input logic dc, input logic [31:0] w);
    int n;
    exp_q.push_back('{e, dc, w});
    @(posedge mclk);
    #1;
    host_req = h;
    mmr_req = !h;
    host_we = we;
    mmr_we = we;
    host_addr = a;
    mmr_addr = a[11:0];
    host_wdata = dd;
    mmr_wdata = dd;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (mmr_ack !== 1'b1 && host_ack !== 1'b1 && n < 20);
    #1;
    host_req = 1'b0;
    mmr_req = 1'b0;
    mmr_wdata = ~dd;
  endtask : loc
  // answer watcher pairs each answer with the oldest note
  always @(posedge mclk) begin
    if (cfg_ack === 1'b1 || mmr_ack === 1'b1 || host_ack === 1'b1) begin
      x = exp_q.pop_front();
      got = cfg_ack ? cfg_rdata : mmr_ack ? mmr_rdata : host_rdata;
      er = mmr_ack ? mmr_err : host_ack ? host_err : 1'b0;
      check({31'h0, er}, {31'h0, x.e});
      if (!x.dc) check(got, x.d);
    end
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    {mmr_req, mmr_we, host_req, host_we, bus_clk_running, n_fail, n_checks, cyc} = '0;
    {mmr_addr, mmr_wdata, host_addr, host_wdata} = '0;
    seed = 32'h13;
    for (int i = 0; i < 6; i++) mask[i] = nxt();
    mask[0] = (mask[0] & 32'hfffff00f) | 32'h80000000; // offset bits stay outside the decode
    for (int i = 0; i < 6; i++) win[i] = 32'h0;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    cfg(1'b0, 6'h0b, 4'hf, 32'h0, 32'h0);
    cfg(1'b0, 6'h0d, 4'hf, 32'h0, 32'h40);
    cfg(1'b0, 6'h0f, 4'hf, 32'h0, 32'h100);
    loc(1'b0, 1'b0, 32'h13c, 32'h0, 1'b1, 1'b1, 32'h0);
    loc(1'b0, 1'b0, 32'h040, 32'h0, 1'b0, 1'b0, 32'h0);
    loc(1'b0, 1'b0, 32'h010, 32'h0, 1'b0, 1'b1, 32'h0);
    bus_clk_running = 1'b1;
    repeat (3) @(posedge mclk);
    loc(1'b0, 1'b0, 32'h040, 32'h0, 1'b0, 1'b0, 32'h1);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        d = nxt();
        b = (p == 0) ? 4'hf : d[3:0];
        m = mask[i] & 32'hfffffff0 & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        cfg(1'b1, 6'(4 + i), b, d, 32'h0);
        win[i] = (win[i] & ~m) | (d & m);
        cfg(1'b0, 6'(4 + i), 4'hf, 32'h0, {win[i][31:4], mask[i][3], 3'b000});
        loc(1'b0, 1'b0, 32'h1e0 + 32'(4 * i), 32'h0, 1'b0, 1'b0, {win[i][31:4], mask[i][3], 3'b000});
      end
    end
    // local writes to a window mirror must not move the window
    loc(1'b0, 1'b1, 32'h1e4, 32'hffffffff, 1'b0, 1'b1, 32'h0);
    cfg(1'b0, 6'h05, 4'hf, 32'h0, {win[1][31:4], mask[1][3], 3'b000});
    d = nxt();
    d2 = nxt();
    cfg(1'b1, 6'h0b, 4'hf, d, 32'h0);
    cfg(1'b1, 6'h0d, 4'hf, d2, 32'h0);
    cfg(1'b1, 6'h0f, 4'hf, d, 32'h0);
    cfg(1'b1, 6'h0f, 4'b0100, d2, 32'h0);
    cfg(1'b0, 6'h0f, 4'hf, 32'h0, {d[31:24], d2[23:16], 8'h01, d[7:0]});
    cfg(1'b0, 6'h0b, 4'hf, 32'h0, 32'h0);
    cfg(1'b0, 6'h0d, 4'hf, 32'h0, 32'h40);
    cfg(1'b0, 6'h3f, 4'hf, 32'h0, 32'h0);
    loc(1'b0, 1'b0, 32'h13c, 32'h0, 1'b0, 1'b0, {d[31:24], d2[23:16], 8'h01, d[7:0]});
    loc(1'b0, 1'b0, 32'h134, 32'h0, 1'b0, 1'b0, 32'h40);
    loc(1'b0, 1'b0, 32'h200, 32'h0, 1'b0, 1'b0, 32'h0);
    // idents are loaded from the local side and only read by config
    loc(1'b0, 1'b1, 32'h12c, d2, 1'b0, 1'b1, 32'h0);
    cfg(1'b0, 6'h0b, 4'hf, 32'h0, d2);
    ha = (win[0] & 32'hfffff000) | 32'h13c;
    loc(1'b1, 1'b0, ha, 32'h0, 1'b0, 1'b0, {d[31:24], d2[23:16], 8'h01, d[7:0]});
    loc(1'b1, 1'b0, ha ^ 32'h80000000, 32'h0, 1'b1, 1'b1, 32'h0);
    // host write through the window; the pin lane stays fixed
    loc(1'b1, 1'b1, ha, d2, 1'b0, 1'b1, 32'h0);
    cfg(1'b0, 6'h0f, 4'hf, 32'h0, {d2[31:16], 8'h01, d2[7:0]});
    m = mask[0];
    mask[0] = 32'h0;
    loc(1'b1, 1'b0, ha, 32'h0, 1'b1, 1'b1, 32'h0);
    mask[0] = m;
    repeat (4) @(posedge mclk);
    complete_run();
  end
endmodule : tb
bind cfgh_regs cfgh_regs_chk #(.NUM_BARS(NUM_BARS)) chk_u (.mclk, .rst, .cfg_req, .cfg_we, .cfg_idx,
  .cfg_rdata, .cfg_ack, .mmr_req, .mmr_addr, .mmr_ack, .mmr_err, .host_req, .host_ack, .host_err,
  .window_write_mask_reg, .bus_clk_running);
`default_nettype wire
